// file: rtl/tdpg_pkg.sv
// Package of constants and types for the two-axis pulse generator.
//
// Overview of operation
// - Host motion commands enter a 2 KB receive FIFO until consumed.
// - One shared analyser drives both axes so interpolated moves advance together.
// - Each period emits the commanded pulses per axis at equal spacing.
// - Period equals cycle value plus one times 1.024 ms.
// - Cycle value spans 1 to 254; host keeps within that range.
// - Per-period pulse count 0 to 2047 yields exactly that many pulses.
// - Format 0 gives separate forward/reverse pulses; 1 gives step plus direction.
// - Direction sense 1 inverts the output rotation.
// - Per-axis servo-on output follows its written setting.
// - X forward motion stops at once on X positive limit.
// - X reverse motion stops at once on X negative limit.
// - Y forward motion stops at once on Y positive limit.
// - Y reverse motion stops at once on Y negative limit.
// - Emergency input terminates all motion on both axes.
// - One polarity bit sets all seven switches: 0 grounded-active, 1 open-active.
// - Device answers at a slot base address, slot 0 to slot 7.
// - Each axis has forward-or-step, reverse-or-direction and servo-on outputs.
// - Each axis has a home switch with the shared polarity.
// - System reset command aborts motion and restores all defaults.
// - FIFO empty and full status are visible to the host.
package tdpg_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte offsets within the slot window)
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_FIFO_DATA = 12'h0_000;
  localparam logic [11:0] ADDR_CONFIG    = 12'h0_004;
  localparam logic [11:0] ADDR_STATUS    = 12'h0_008;
  localparam logic [11:0] ADDR_CONTROL   = 12'h0_00C;

  // Slot base addresses.
  localparam logic [11:0] SLOT_BASE [8] = '{12'h0_080, 12'h0_0A0, 12'h0_0C0, 12'h0_0E0,
                                            12'h0_140, 12'h0_160, 12'h0_180, 12'h0_1A0};
  localparam logic [11:0] SLOT_MASK = 12'h0_01F;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_CYCLE_LSB   = 0;
  localparam int CFG_X_FMT_BIT   = 8;
  localparam int CFG_Y_FMT_BIT   = 9;
  localparam int CFG_X_DIR_BIT   = 10;
  localparam int CFG_Y_DIR_BIT   = 11;
  localparam int CFG_X_SON_BIT   = 12;
  localparam int CFG_Y_SON_BIT   = 13;
  localparam int CFG_POL_BIT     = 14;
  localparam int CTL_RESET_BIT   = 0;
  localparam int CMD_X_LSB       = 0;
  localparam int CMD_X_DIR_BIT   = 11;
  localparam int CMD_Y_LSB       = 16;
  localparam int CMD_Y_DIR_BIT   = 27;

  // ----------------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CYCLE_RESET  = 8'h01;
  localparam logic [7:0]  CYCLE_MIN    = 8'h01;
  localparam logic [7:0]  CYCLE_MAX    = 8'hFE;
  localparam int          FIFO_BYTES   = 2048;
  localparam int          FIFO_DEPTH   = FIFO_BYTES / 4;
  localparam int          FIFO_AW      = 9;
  localparam logic [10:0] COUNT_MAX    = 11'h7_FF;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int BASE_TICK_NS  = 1024000;
  localparam int BASE_TICK_CYC = BASE_TICK_NS / (1_000_000_000 / CLK_HZ);
  localparam int FILT_CYC      = 4;

  typedef enum logic [1:0] {TDPG_IDLE, TDPG_RUN} tdpg_state_t;

endpackage

// file: rtl/tdpg_top.sv
// Two-axis stepping pulse generator with APB register access.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module tdpg_top #(
  parameter logic [2:0]  SLOT          = 3'h0,
  parameter int unsigned BASE_TICK_CYC = tdpg_pkg::BASE_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        emergency_stop_n,
  input  wire logic        x_home_switch_n,
  input  wire logic        y_home_switch_n,
  input  wire logic        x_negative_limit_n,
  input  wire logic        x_positive_limit_n,
  input  wire logic        y_negative_limit_n,
  input  wire logic        y_positive_limit_n,
  output logic             x_forward_step_out,
  output logic             x_reverse_or_sense_out,
  output logic             x_servo_on_out,
  output logic             y_forward_step_out,
  output logic             y_reverse_or_sense_out,
  output logic             y_servo_on_out
);

  localparam int FIFO_AWP = tdpg_pkg::FIFO_AW;
  localparam int FD       = tdpg_pkg::FIFO_DEPTH;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
    logic [7:0]           cycle;
    logic [1:0]           fmt;
    logic [1:0]           dsense;
    logic [1:0]           son;
    logic                 pol;
    logic [6:0]           sync1;
    logic [6:0]           sync2;
    logic [6:0]           sw;
    logic [6:0][2:0]      filt;
    logic [FIFO_AWP:0]    wptr;
    logic [FIFO_AWP:0]    rptr;
    tdpg_pkg::tdpg_state_t st;
    logic [31:0]          tick;
    logic [7:0]           per;
    logic [10:0]          slot_i;
    logic [1:0][10:0]     cnt;
    logic [1:0][11:0]     acc;
    logic [1:0]           dir;
    logic [1:0]           stopped;
    logic [1:0]           pulse;
    logic [5:0]           pins;
  } tdpg_state_s_t;

  tdpg_state_s_t r;
  tdpg_state_s_t next_r;
  logic [31:0]   fifo_mem [FD];
  logic [31:0]   fifo_q;
  logic          fifo_we;

  // Active-level of a switch after polarity: grounded pin reads 0.
  function automatic logic sw_active(input logic pin_n, input logic pol);
    sw_active = pol ? pin_n : ~pin_n;
  endfunction

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    addr_hit = (a == (tdpg_pkg::SLOT_BASE[SLOT] | off));
  endfunction

  // ----------------------------------------------------------------------
  // Command FIFO storage
  // ----------------------------------------------------------------------
  // Kept outside the struct so the array maps onto block memory.
  always_ff @(posedge clk)
  begin
    if (fifo_we)
    begin
      fifo_mem[r.wptr[FIFO_AWP-1:0]] <= pwdata;
    end
  end
  assign fifo_q = fifo_mem[r.rptr[FIFO_AWP-1:0]];

  logic       fifo_empty;
  logic       fifo_full;
  logic       apb_acc;
  logic [6:0] pins_in;
  assign fifo_empty = (r.wptr == r.rptr);
  assign fifo_full  = (r.wptr[FIFO_AWP] != r.rptr[FIFO_AWP]) &&
                      (r.wptr[FIFO_AWP-1:0] == r.rptr[FIFO_AWP-1:0]);
  // Taking the access only while pready is low keeps a held request from being served twice.
  assign apb_acc    = psel && penable && !r.pready;
  assign fifo_we    = apb_acc && pwrite && !fifo_full && !srst &&
                      addr_hit(paddr, tdpg_pkg::ADDR_FIFO_DATA);
  assign pins_in    = {y_home_switch_n, x_home_switch_n, y_positive_limit_n,
                       y_negative_limit_n, x_positive_limit_n, x_negative_limit_n,
                       emergency_stop_n};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic        sys_reset;
    logic        load;
    logic        lim_pos;
    logic        lim_neg;
    logic [11:0] sum;
    logic        fwd;
    logic        dir_pin;
    next_r    = r;
    sys_reset = 1'b0;
    load      = 1'b0;
    lim_pos   = 1'b0;
    lim_neg   = 1'b0;
    sum       = 12'h0_000;
    fwd       = 1'b0;
    dir_pin   = 1'b0;

    // --------------------------------------------------------------------
    // Bus decode
    // --------------------------------------------------------------------
    // APB slave: one wait state, so every access answers two cycles after setup.
    next_r.pready  = apb_acc;
    next_r.pslverr = 1'b0;
    next_r.prdata  = 32'h0000_0000;
    if (apb_acc)
    begin
      if (addr_hit(paddr, tdpg_pkg::ADDR_FIFO_DATA))
      begin
        next_r.pslverr = pwrite ? fifo_full : 1'b1;
        if (fifo_we)
        begin
          next_r.wptr = r.wptr + 1'b1;
        end
      end
      else if (addr_hit(paddr, tdpg_pkg::ADDR_CONFIG))
      begin
        if (pwrite)
        begin
          // Limitation: a cycle value outside 1 to 254 is stored as written.
          next_r.cycle  = pwdata[tdpg_pkg::CFG_CYCLE_LSB +: 8];
          next_r.fmt    = {pwdata[tdpg_pkg::CFG_Y_FMT_BIT], pwdata[tdpg_pkg::CFG_X_FMT_BIT]};
          next_r.dsense = {pwdata[tdpg_pkg::CFG_Y_DIR_BIT], pwdata[tdpg_pkg::CFG_X_DIR_BIT]};
          next_r.son    = {pwdata[tdpg_pkg::CFG_Y_SON_BIT], pwdata[tdpg_pkg::CFG_X_SON_BIT]};
          next_r.pol    = pwdata[tdpg_pkg::CFG_POL_BIT];
        end
        next_r.prdata = {17'h0_0000, r.pol, r.son, r.dsense, r.fmt, r.cycle};
      end
      else if (addr_hit(paddr, tdpg_pkg::ADDR_STATUS))
      begin
        next_r.pslverr = pwrite;
        next_r.prdata  = {20'h0_0000, r.stopped, r.st == tdpg_pkg::TDPG_RUN,
                          r.sw, fifo_full, fifo_empty};
      end
      else if (addr_hit(paddr, tdpg_pkg::ADDR_CONTROL))
      begin
        sys_reset = pwrite && pwdata[tdpg_pkg::CTL_RESET_BIT];
      end
      else
      begin
        next_r.pslverr = 1'b1;
      end
    end

    // --------------------------------------------------------------------
    // Switch conditioning
    // --------------------------------------------------------------------
    // Two-flop synchroniser and a filter on each switch that flips only after four consecutive differing samples.
    next_r.sync1 = pins_in;
    next_r.sync2 = r.sync1;
    for (int i = 0; i < 7; i++)
    begin
      if (sw_active(r.sync2[i], r.pol) != r.sw[i])
      begin
        next_r.filt[i] = r.filt[i] + 3'h1;
        if (r.filt[i] == 3'(tdpg_pkg::FILT_CYC - 1))
        begin
          next_r.sw[i]   = ~r.sw[i];
          next_r.filt[i] = 3'h0;
        end
      end
      else
      begin
        next_r.filt[i] = 3'h0;
      end
    end

    // --------------------------------------------------------------------
    // Analyser
    // --------------------------------------------------------------------
    // Base tick and analyser period; both axes share one period counter.
    next_r.pulse = 2'b00;
    next_r.tick  = r.tick + 32'h0000_0001;
    if (r.tick == BASE_TICK_CYC - 1)
    begin
      next_r.tick = 32'h0000_0000;
      next_r.per  = r.per + 8'h01;
      if (r.per == r.cycle)
      begin
        next_r.per = 8'h00;
        load       = 1'b1;
      end
    end

    case (r.st)
      tdpg_pkg::TDPG_IDLE:
      begin
        // A command waits for the boundary so both axes start on the shared time base.
        if (load && !fifo_empty)
        begin
          load = 1'b0;
          next_r.st = tdpg_pkg::TDPG_RUN;
        end
      end
      tdpg_pkg::TDPG_RUN:
      begin
        // The load cycle and slots 0 to 2046 make 2048 additions, so the accumulator
        // overflows exactly n times and the last pulse still falls inside the window.
        if (r.slot_i != tdpg_pkg::COUNT_MAX)
        begin
          next_r.slot_i = r.slot_i + 11'h001;
        end
        for (int a = 0; a < 2; a++)
        begin
          if (r.slot_i != tdpg_pkg::COUNT_MAX)
          begin
            sum = r.acc[a] + {1'b0, r.cnt[a]};
            next_r.acc[a] = {1'b0, sum[10:0]};
            next_r.pulse[a] = sum[11] && !r.stopped[a];
          end
        end
        if (load)
        begin
          next_r.st = tdpg_pkg::TDPG_IDLE;
        end
      end
      default:
      begin
        next_r.st = tdpg_pkg::TDPG_IDLE;
      end
    endcase

    // New period: pop one command carrying both axis counts together.
    if (load || (r.st == tdpg_pkg::TDPG_IDLE && next_r.st == tdpg_pkg::TDPG_RUN))
    begin
      next_r.slot_i  = 11'h000;
      next_r.acc[0]  = 12'h0_000;
      next_r.acc[1]  = 12'h0_000;
      next_r.stopped = 2'b00;
      if (!fifo_empty)
      begin
        next_r.cnt[0] = fifo_q[tdpg_pkg::CMD_X_LSB +: 11];
        next_r.cnt[1] = fifo_q[tdpg_pkg::CMD_Y_LSB +: 11];
        // First addition of the period; a count below 2048 cannot overflow here.
        next_r.acc[0] = {1'b0, fifo_q[tdpg_pkg::CMD_X_LSB +: 11]};
        next_r.acc[1] = {1'b0, fifo_q[tdpg_pkg::CMD_Y_LSB +: 11]};
        next_r.dir    = {fifo_q[tdpg_pkg::CMD_Y_DIR_BIT], fifo_q[tdpg_pkg::CMD_X_DIR_BIT]};
        next_r.rptr   = r.rptr + 1'b1;
        next_r.st     = tdpg_pkg::TDPG_RUN;
      end
      else
      begin
        next_r.st = tdpg_pkg::TDPG_IDLE;
      end
    end

    // --------------------------------------------------------------------
    // Protection
    // --------------------------------------------------------------------
    // Limit protection blocks only the motion toward the touched limit.
    for (int a = 0; a < 2; a++)
    begin
      lim_pos = (a == 0) ? r.sw[2] : r.sw[4];
      lim_neg = (a == 0) ? r.sw[1] : r.sw[3];
      if ((!next_r.dir[a] && lim_pos) || (next_r.dir[a] && lim_neg))
      begin
        next_r.stopped[a] = 1'b1;
        next_r.pulse[a]   = 1'b0;
      end
    end

    // Emergency and system reset both abort everything.
    if (r.sw[0] || sys_reset)
    begin
      next_r.st      = tdpg_pkg::TDPG_IDLE;
      // Flushing to the next write pointer also drops a word written in this cycle.
      next_r.rptr    = next_r.wptr;
      next_r.pulse   = 2'b00;
      next_r.cnt[0]  = 11'h000;
      next_r.cnt[1]  = 11'h000;
      next_r.stopped = 2'b11;
    end
    if (sys_reset)
    begin
      next_r.cycle  = tdpg_pkg::CYCLE_RESET;
      next_r.fmt    = 2'b00;
      next_r.dsense = 2'b00;
      next_r.son    = 2'b00;
      next_r.pol    = 1'b0;
      next_r.rptr   = r.wptr;
      next_r.wptr   = r.wptr;
    end

    // --------------------------------------------------------------------
    // Output pins
    // --------------------------------------------------------------------
    // Output pin formatting.
    for (int a = 0; a < 2; a++)
    begin
      fwd     = next_r.dir[a] == 1'b0;
      dir_pin = fwd ^ r.dsense[a];
      if (r.fmt[a])
      begin
        next_r.pins[3*a]   = next_r.pulse[a];
        next_r.pins[3*a+1] = dir_pin;
      end
      else
      begin
        next_r.pins[3*a]   = next_r.pulse[a] && dir_pin;
        next_r.pins[3*a+1] = next_r.pulse[a] && !dir_pin;
      end
      next_r.pins[3*a+2] = r.son[a];
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r        <= '0;
      r.cycle  <= tdpg_pkg::CYCLE_RESET;
      r.st     <= tdpg_pkg::TDPG_IDLE;
      // Synchronisers start at the idle pin level so no false switch event follows reset.
      r.sync1  <= 7'h7F;
      r.sync2  <= 7'h7F;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign pready                 = r.pready;
  assign prdata                 = r.prdata;
  assign pslverr                = r.pslverr;
  assign x_forward_step_out     = r.pins[0];
  assign x_reverse_or_sense_out = r.pins[1];
  assign x_servo_on_out         = r.pins[2];
  assign y_forward_step_out     = r.pins[3];
  assign y_reverse_or_sense_out = r.pins[4];
  assign y_servo_on_out         = r.pins[5];

endmodule

// file: sim/tdpg_monitor.sv
// Checker of bus timing and output behaviour of the pulse generator.
`timescale 1ns/1ps
module tdpg_monitor (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        x_forward_step_out,
  input wire logic        y_forward_step_out,
  input wire logic        x_servo_on_out,
  input wire logic        y_servo_on_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [11:0] run_len;
  logic [3:0]  since_wr;
  // Counters saturate so a long high step run or a long gap between writes cannot wrap into a false pass.
  always_ff @(posedge clk)
  begin
    if (srst || !x_forward_step_out) run_len <= 12'h000;
    else if (run_len != 12'hFFF) run_len <= run_len + 12'h001;
    if (srst || (psel && pwrite)) since_wr <= 4'h0;
    else if (since_wr != 4'hF) since_wr <= since_wr + 4'h1;
  end
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held for more than one cycle");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready without an access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside answer");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag outside answer");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !pready && !x_forward_step_out
    && !y_forward_step_out && !x_servo_on_out && !y_servo_on_out)
    else $error("outputs active after reset");
  a_step_run: assert property (run_len <= 12'd2047)
    else $error("step output high too long for one period");
  a_servo_write: assert property ($changed({x_servo_on_out, y_servo_on_out}) |-> since_wr < 4'd4)
    else $error("servo output changed without a write");
endmodule
bind tdpg_top tdpg_monitor u_tdpg_monitor (.clk, .srst, .psel, .penable, .pwrite, .pready,
  .prdata, .pslverr, .x_forward_step_out, .y_forward_step_out, .x_servo_on_out, .y_servo_on_out);

// file: sim/tdpg_motor_model.sv
// Motor driver stand-in that counts the X forward, X reverse and Y forward pulses it receives.
`timescale 1ns/1ps
module tdpg_motor_model (
  input wire logic        clk,
  input wire logic        clr,
  input wire logic        x_fwd,
  input wire logic        x_rev,
  input wire logic        y_fwd,
  output logic     [15:0] n_xf,
  output logic     [15:0] n_xr,
  output logic     [15:0] n_yf
);
  // Pulses are one clock wide, so high cycles are counted, not edges: at full rate
  // adjacent pulses merge into one long high level with a single rising edge.
  always_ff @(posedge clk)
  begin
    n_xf <= clr ? 16'h0000 : n_xf + 16'(x_fwd);
    n_xr <= clr ? 16'h0000 : n_xr + 16'(x_rev);
    n_yf <= clr ? 16'h0000 : n_yf + 16'(y_fwd);
  end
endmodule

// file: sim/tb.sv
// Self-checking bench for the two-axis pulse generator.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %0h want %0h", $time, (a), (b)); end end
module tb;
  localparam int          TICK = 2100;
  localparam int          WAIT = 2 * TICK + 2100;
  localparam logic [11:0] BASE = 12'h0_0C0;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, clr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        emergency_stop_n, x_home_switch_n, y_home_switch_n;
  logic        x_negative_limit_n, x_positive_limit_n, y_negative_limit_n, y_positive_limit_n;
  logic        x_forward_step_out, x_reverse_or_sense_out, x_servo_on_out;
  logic        y_forward_step_out, y_reverse_or_sense_out, y_servo_on_out;
  logic [15:0] n_xf, n_xr, n_yf;
  int          n_fail, n_tests;

  tdpg_top #(.SLOT(3'h2), .BASE_TICK_CYC(TICK)) u_tdpg_top (.clk, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .emergency_stop_n, .x_home_switch_n,
    .y_home_switch_n, .x_negative_limit_n, .x_positive_limit_n, .y_negative_limit_n,
    .y_positive_limit_n, .x_forward_step_out, .x_reverse_or_sense_out, .x_servo_on_out,
    .y_forward_step_out, .y_reverse_or_sense_out, .y_servo_on_out);
  tdpg_motor_model u_tdpg_motor_model (.clk, .clr, .x_fwd(x_forward_step_out),
    .x_rev(x_reverse_or_sense_out), .y_fwd(y_forward_step_out), .n_xf, .n_xr, .n_yf);

  // ----------------------------------------------------------------------
  // Bus and motion tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // The wait covers one period until the next boundary plus the pulse window after it.
  task automatic move(input logic [31:0] c, input logic [15:0] xf, xr, yf);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    apb(1'b1, BASE, c);
    repeat (WAIT) @(posedge clk);
    `CHK({n_xf, n_xr, n_yf}, {xf, xr, yf})
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    {psel, penable, pwrite, clr, srst} = 5'b00001;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {emergency_stop_n, x_home_switch_n, y_home_switch_n, x_negative_limit_n,
      x_positive_limit_n, y_negative_limit_n, y_positive_limit_n} = 7'h7F;
    n_fail = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, BASE + 12'h004, 32'h0);
    `CHK(rd, 32'h0000_0001)
    apb(1'b0, BASE + 12'h008, 32'h0);
    `CHK(rd[1:0], 2'b01)
    apb(1'b1, BASE + 12'h004, 32'h0000_3201);
    move(32'h07FF_0005, 16'd5, 16'd0, 16'd2047);
    `CHK({x_servo_on_out, y_servo_on_out, y_reverse_or_sense_out}, 3'b111)
    move(32'h0000_0803, 16'd0, 16'd3, 16'd0);
    `CHK(y_reverse_or_sense_out, 1'b1)
    apb(1'b1, BASE + 12'h004, 32'h0000_3E01);
    move(32'h0001_0004, 16'd0, 16'd4, 16'd1);
    `CHK(y_reverse_or_sense_out, 1'b0)
    for (int i = 0; i < 2; i++)
    begin
      {x_positive_limit_n, y_negative_limit_n} <= {2{i[0]}};
      {x_negative_limit_n, y_positive_limit_n} <= {2{~i[0]}};
      apb(1'b1, BASE + 12'h004, 32'h0000_3201);
      move(i ? 32'h0007_0864 : 32'h0807_0064, 16'd0, 16'd0, 16'd0);
      move(i ? 32'h0806_0004 : 32'h0006_0804, i ? 16'd4 : 16'd0, i ? 16'd0 : 16'd4, 16'd6);
    end
    {emergency_stop_n, x_home_switch_n, y_home_switch_n, x_negative_limit_n,
      x_positive_limit_n, y_negative_limit_n, y_positive_limit_n} <= 7'h60;
    apb(1'b1, BASE + 12'h004, 32'h0000_7201);
    move(32'h0009_0009, 16'd0, 16'd0, 16'd0);
    apb(1'b0, BASE + 12'h008, 32'h0);
    `CHK(rd[8:2], 7'b0100001)
    emergency_stop_n <= 1'b0;
    // The filter must see the released pin long enough before a command may land.
    repeat (8) @(posedge clk);
    move(32'h0009_0009, 16'd9, 16'd0, 16'd9);
    apb(1'b0, BASE + 12'h010, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, BASE + 12'h008, 32'h0);
    `CHK(er, 1'b1)
    // A long period keeps the analyser from popping a word while the FIFO fills.
    apb(1'b1, BASE + 12'h004, 32'h0000_70FE);
    for (int i = 0; i < 520; i++) apb(1'b1, BASE, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b0, BASE + 12'h008, 32'h0);
    `CHK(rd[1:0], 2'b10)
    apb(1'b1, BASE + 12'h00C, 32'h0000_0001);
    apb(1'b0, BASE + 12'h004, 32'h0);
    `CHK(rd, 32'h0000_0001)
    apb(1'b0, BASE + 12'h008, 32'h0);
    `CHK(rd[1:0], 2'b01)
    end_sim();
  end
endmodule
